// >>> fflb_bank.sv
// Bank of edge registers and gated latches sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "fflb_defs.svh"
// Summary of operation
// - Clear low forces true 0 and inverted 1, preset low forces true 1 and inverted 0, ignoring clock and data.
// - Preset and clear both low drive both outputs to 1 and raise the unstable flag.
// - The rising-edge D register loads data on a rising clock and holds on a static clock.
// - The falling-edge J-K register holds, clears, sets or toggles on a falling clock by J and K.
// - The dual-edge D register captures on each edge whose enable is 1 and holds otherwise.
// - The dual-edge J-K register applies the J-K action on each edge whose enable is 1 and holds otherwise.
// - Preset and clear of the dual-edge registers work as on the others and beat clock and enables.
// - The latch part comes as exactly two groups, a set-reset latch and a D latch.
// - With gate 1 the set-reset latch holds, resets, sets, or shows both outputs 1 for S and R both 1; gate 0 holds.
// - The D latch follows its data while the gate is 1 and holds while it is 0.
// - Preset, clear and gate of a latch group are shared by all its bits.
// - The bit count of a latch group is a build parameter that sizes its vectors.
module fflb_bank #(
	parameter int RW = 4,
	parameter int LW = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic rd_clk,
	input wire logic rd_preset_n,
	input wire logic rd_async_clear_n,
	input wire logic [RW-1:0] rd_d,
	output logic [RW-1:0] rd_q,
	output logic [RW-1:0] rd_q_n,
	output logic rd_unstable,
	input wire logic fj_clk,
	input wire logic fj_preset_n,
	input wire logic fj_async_clear_n,
	input wire logic [RW-1:0] fj_j,
	input wire logic [RW-1:0] fj_k,
	output logic [RW-1:0] fj_q,
	output logic [RW-1:0] fj_q_n,
	output logic fj_unstable,
	input wire logic dd_clk,
	input wire logic dd_rise_edge_enable,
	input wire logic dd_fall_edge_enable,
	input wire logic dd_preset_n,
	input wire logic dd_async_clear_n,
	input wire logic [RW-1:0] dd_d,
	output logic [RW-1:0] dd_q,
	output logic [RW-1:0] dd_q_n,
	output logic dd_unstable,
	input wire logic dj_clk,
	input wire logic dj_rise_edge_enable,
	input wire logic dj_fall_edge_enable,
	input wire logic dj_preset_n,
	input wire logic dj_async_clear_n,
	input wire logic [RW-1:0] dj_j,
	input wire logic [RW-1:0] dj_k,
	output logic [RW-1:0] dj_q,
	output logic [RW-1:0] dj_q_n,
	output logic dj_unstable,
	input wire logic sr_gate,
	input wire logic sr_preset_n,
	input wire logic sr_async_clear_n,
	input wire logic [LW-1:0] sr_set,
	input wire logic [LW-1:0] sr_reset,
	output logic [LW-1:0] sr_q,
	output logic [LW-1:0] sr_q_n,
	output logic sr_unstable,
	input wire logic dl_gate,
	input wire logic dl_preset_n,
	input wire logic dl_async_clear_n,
	input wire logic [LW-1:0] dl_d,
	output logic [LW-1:0] dl_q,
	output logic [LW-1:0] dl_q_n,
	output logic dl_unstable
);
	import fflb_pkg::*;

	typedef struct packed {
		logic [RW-1:0] st;
		logic [RW-1:0] q;
		logic [RW-1:0] q_n;
		logic unst;
		logic prev;
		logic primed;
	} fflb_reg_t;

	typedef struct packed {
		fflb_reg_t rd;
		fflb_reg_t fj;
		fflb_reg_t dd;
		fflb_reg_t dj;
	} fflb_bank_t;

	localparam fflb_reg_t REG_RST = '{st: {RW{`FFLB_STATE_RST}},
		q: {RW{`FFLB_Q_RST}}, q_n: {RW{`FFLB_QN_RST}}, unst: 1'b0,
		prev: `FFLB_PREV_RST, primed: `FFLB_PRIMED_RST};

	fflb_bank_t s;
	fflb_bank_t next_s;

	// One step of a register group. A D register is run as a J-K register
	// with K the inverse of J, so every variant shares one action table.
	// No edge is seen on the first sample after reset, since the clock level
	// before it is unknown and a high level must not pass for a rising edge.
	function automatic fflb_reg_t step(input fflb_reg_t cur,
			input logic clk, input logic pre_n, input logic clr_n,
			input logic rise_en, input logic fall_en,
			input logic [RW-1:0] j, input logic [RW-1:0] k);
		fflb_reg_t nx;
		logic fire;
		nx = cur;
		fire = cur.primed && ((rise_en && !cur.prev && clk)
			|| (fall_en && cur.prev && !clk));
		nx.prev = clk;
		nx.primed = 1'b1;
		nx.unst = !pre_n && !clr_n;
		if (nx.unst) begin
			nx.st = '1;
		end else if (!clr_n) begin
			nx.st = '0;
		end else if (!pre_n) begin
			nx.st = '1;
		end else if (fire) begin
			for (int i = 0; i < RW; i++) begin
				nx.st[i] = fflb_jk_next(cur.st[i], j[i], k[i]);
			end
		end
		nx.q = nx.st | {RW{nx.unst}};
		nx.q_n = ~nx.st | {RW{nx.unst}};
		return nx;
	endfunction : step

	always_comb begin
		next_s.rd = step(s.rd, rd_clk, rd_preset_n, rd_async_clear_n,
			1'b1, 1'b0, rd_d, ~rd_d);
		next_s.fj = step(s.fj, fj_clk, fj_preset_n, fj_async_clear_n,
			1'b0, 1'b1, fj_j, fj_k);
		next_s.dd = step(s.dd, dd_clk, dd_preset_n, dd_async_clear_n,
			dd_rise_edge_enable, dd_fall_edge_enable, dd_d, ~dd_d);
		next_s.dj = step(s.dj, dj_clk, dj_preset_n, dj_async_clear_n,
			dj_rise_edge_enable, dj_fall_edge_enable, dj_j, dj_k);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '{rd: REG_RST, fj: REG_RST, dd: REG_RST, dj: REG_RST};
		end else begin
			s <= next_s;
		end
	end

	assign rd_q = s.rd.q;
	assign rd_q_n = s.rd.q_n;
	assign rd_unstable = s.rd.unst;
	assign fj_q = s.fj.q;
	assign fj_q_n = s.fj.q_n;
	assign fj_unstable = s.fj.unst;
	assign dd_q = s.dd.q;
	assign dd_q_n = s.dd.q_n;
	assign dd_unstable = s.dd.unst;
	assign dj_q = s.dj.q;
	assign dj_q_n = s.dj.q_n;
	assign dj_unstable = s.dj.unst;

	// Exactly two latch groups: set-reset, and D built as set-reset with
	// reset the inverse of set, which reaches the unstable state only with preset and clear both low.
	fflb_latch_if #(.N(LW)) sr_if ();
	fflb_latch_if #(.N(LW)) dl_if ();

	assign sr_if.gate = sr_gate;
	assign sr_if.preset_n = sr_preset_n;
	assign sr_if.async_clear_n = sr_async_clear_n;
	assign sr_if.set_in = sr_set;
	assign sr_if.reset_in = sr_reset;
	assign sr_q = sr_if.q;
	assign sr_q_n = sr_if.q_n;
	assign sr_unstable = sr_if.unstable;

	assign dl_if.gate = dl_gate;
	assign dl_if.preset_n = dl_preset_n;
	assign dl_if.async_clear_n = dl_async_clear_n;
	assign dl_if.set_in = dl_d;
	assign dl_if.reset_in = ~dl_d;
	assign dl_q = dl_if.q;
	assign dl_q_n = dl_if.q_n;
	assign dl_unstable = dl_if.unstable;

	fflb_latch #(.N(LW)) u_sr_latch (
		.mclk(mclk),
		.rstn(rstn),
		.lif(sr_if)
	);

	fflb_latch #(.N(LW)) u_d_latch (
		.mclk(mclk),
		.rstn(rstn),
		.lif(dl_if)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence rd_live_rise;
		$rose(rd_clk) && rd_preset_n && rd_async_clear_n && s.rd.primed;
	endsequence
	sequence fj_live_fall;
		$fell(fj_clk) && fj_preset_n && fj_async_clear_n && s.fj.primed;
	endsequence
	sequence dd_live_fall;
		$fell(dd_clk) && dd_fall_edge_enable && dd_preset_n
			&& dd_async_clear_n && s.dd.primed;
	endsequence
	sequence dj_live_rise;
		$rose(dj_clk) && dj_rise_edge_enable && dj_preset_n
			&& dj_async_clear_n && s.dj.primed;
	endsequence
	sequence dd_live_rise;
		$rose(dd_clk) && dd_rise_edge_enable && dd_preset_n
			&& dd_async_clear_n && s.dd.primed;
	endsequence
	sequence dj_live_fall;
		$fell(dj_clk) && dj_fall_edge_enable && dj_preset_n
			&& dj_async_clear_n && s.dj.primed;
	endsequence

	a_rd_clear_force: assert property (
		!rd_async_clear_n && rd_preset_n |=> rd_q == '0 && rd_q_n == '1)
		else $error("clear did not force the rising D register low");
	a_fj_preset_force: assert property (
		fj_async_clear_n && !fj_preset_n |=> fj_q == '1 && fj_q_n == '0)
		else $error("preset did not force the J-K register high");
	a_dd_both_low: assert property (
		!dd_preset_n && !dd_async_clear_n
		|=> dd_q == '1 && dd_q_n == '1 && dd_unstable)
		else $error("both low did not give ones and unstable flag");
	a_rd_rise_load: assert property (
		rd_live_rise |=> rd_q == $past(rd_d) && rd_q_n == ~$past(rd_d))
		else $error("rising D register missed its data");
	a_rd_static_hold: assert property (
		$stable(rd_clk) && rd_preset_n && rd_async_clear_n
		|=> $stable(rd_q))
		else $error("rising D register moved on a static clock");
	a_fj_fall_action: assert property (
		fj_live_fall |=> fj_q == (($past(fj_j) & ~$past(fj_q))
			| (~$past(fj_k) & $past(fj_q))))
		else $error("falling J-K register took a wrong action");
	a_dd_fall_capture: assert property (
		dd_live_fall |=> dd_q == $past(dd_d))
		else $error("dual-edge D register missed a falling edge");
	a_dd_disabled_hold: assert property (
		!dd_rise_edge_enable && !dd_fall_edge_enable && dd_preset_n
		&& dd_async_clear_n |=> $stable(dd_q))
		else $error("dual-edge D register moved with enables low");
	a_dj_rise_action: assert property (
		dj_live_rise |=> dj_q == (($past(dj_j) & ~$past(dj_q))
			| (~$past(dj_k) & $past(dj_q))))
		else $error("dual-edge J-K register took a wrong action");
	a_dj_clear_wins: assert property (
		!dj_async_clear_n && dj_preset_n
		&& dj_rise_edge_enable && dj_fall_edge_enable
		|=> dj_q == '0 && dj_q_n == '1)
		else $error("clock beat clear on the dual-edge J-K register");
	a_dj_complement: assert property (
		!dj_unstable |-> dj_q_n == ~dj_q)
		else $error("dual-edge J-K outputs not complementary");
	a_dl_complement: assert property (
		!dl_unstable |-> dl_q_n == ~dl_q)
		else $error("D latch outputs not complementary");
	a_sr_both_set: assert property (
		sr_gate && sr_preset_n && sr_async_clear_n && |(sr_set & sr_reset)
		|=> sr_unstable && (sr_q & sr_q_n) == $past(sr_set & sr_reset))
		else $error("set and reset together did not give both ones");

	a_dd_rise_capture: assert property (
		dd_live_rise |=> dd_q == $past(dd_d) && dd_q_n == ~$past(dd_d))
		else $error("dual-edge D register missed a rising edge");
	a_dj_fall_action: assert property (
		dj_live_fall |=> dj_q == (($past(dj_j) & ~$past(dj_q))
			| (~$past(dj_k) & $past(dj_q))))
		else $error("dual-edge J-K register failed a falling edge");
	a_fj_static_hold: assert property (
		$stable(fj_clk) && fj_preset_n && fj_async_clear_n
		|=> $stable(fj_q))
		else $error("falling J-K register moved on a static clock");
	a_dj_disabled_hold: assert property (
		!dj_rise_edge_enable && !dj_fall_edge_enable && dj_preset_n
		&& dj_async_clear_n |=> $stable(dj_q))
		else $error("dual-edge J-K register moved with enables low");
	a_dd_preset_wins: assert property (
		!dd_preset_n && dd_async_clear_n
		&& dd_rise_edge_enable && dd_fall_edge_enable
		|=> dd_q == '1 && dd_q_n == '0)
		else $error("clock beat preset on the dual-edge D register");
	a_fj_both_low: assert property (
		!fj_preset_n && !fj_async_clear_n
		|=> fj_q == '1 && fj_q_n == '1 && fj_unstable)
		else $error("J-K register did not flag both low");
	a_fj_clear_force: assert property (
		!fj_async_clear_n && fj_preset_n |=> fj_q == '0 && fj_q_n == '1)
		else $error("clear did not force the J-K register low");
	a_rd_complement: assert property (
		!rd_unstable |-> rd_q_n == ~rd_q)
		else $error("rising D register outputs not complementary");
	a_sr_no_flag: assert property (
		sr_preset_n && sr_async_clear_n
		&& !(sr_gate && |(sr_set & sr_reset))
		|=> !sr_unstable)
		else $error("set-reset latch flagged a stable state");
	a_dl_hold_low: assert property (
		!dl_gate && dl_preset_n && dl_async_clear_n
		|=> $stable(dl_q))
		else $error("D latch moved with its gate low");
	a_dl_follow: assert property (
		dl_gate && dl_preset_n && dl_async_clear_n
		|=> dl_q == $past(dl_d) && dl_q_n == ~$past(dl_d))
		else $error("D latch did not follow its data");
endmodule : fflb_bank
`default_nettype wire

// >>> fflb_defs.svh
// Reset values shared by the storage bank modules.
`ifndef FFLB_DEFS_SVH
`define FFLB_DEFS_SVH
`define FFLB_STATE_RST 1'b0
`define FFLB_Q_RST 1'b0
`define FFLB_QN_RST 1'b1
`define FFLB_PREV_RST 1'b0
`define FFLB_PRIMED_RST 1'b0
`endif

// >>> fflb_far.sv
// Surrounding synchronous logic that registers stimulus onto the bank.
`timescale 1ns/1ps
`default_nettype none
module fflb_far (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [4:0] sc [6],
	input wire logic [3:0] sa [6],
	input wire logic [3:0] sb [6],
	output logic [4:0] pc [6],
	output logic [3:0] pa [6],
	output logic [3:0] pb [6]
);
	// Every level is held a whole mclk, so no element edge is too short.
	always_ff @(posedge mclk or negedge rstn) begin
		for (int g = 0; g < 6; g++) begin
			if (!rstn) begin
				pc[g] <= 5'h0C;
				pa[g] <= 4'h0;
				pb[g] <= 4'h0;
			end else begin
				pc[g] <= sc[g];
				pa[g] <= sa[g];
				pb[g] <= sb[g];
			end
		end
	end
endmodule : fflb_far
`default_nettype wire

// >>> fflb_latch.sv
// Gated set-reset latch group with shared preset, clear and gate.
`timescale 1ns/1ps
`default_nettype none
`include "fflb_defs.svh"
module fflb_latch #(
	parameter int N = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	fflb_latch_if.latch lif
);
	import fflb_pkg::*;

	typedef struct packed {
		logic [N-1:0] st;
		logic [N-1:0] both;
		logic [N-1:0] q;
		logic [N-1:0] q_n;
		logic unst;
	} fflb_latch_t;

	localparam fflb_latch_t RST = '{st: {N{`FFLB_STATE_RST}},
		both: '0, q: {N{`FFLB_Q_RST}}, q_n: {N{`FFLB_QN_RST}}, unst: 1'b0};

	fflb_latch_t s;
	fflb_latch_t next_s;

	// Gate, preset and clear are one wire each for every bit.
	always_comb begin
		next_s = s;
		next_s.both = '0;
		if (!lif.preset_n && !lif.async_clear_n) begin
			next_s.st = '1;
			next_s.both = '1;
		end else if (!lif.async_clear_n) begin
			next_s.st = '0;
		end else if (!lif.preset_n) begin
			next_s.st = '1;
		end else if (lif.gate) begin
			next_s.st = lif.set_in | (s.st & ~lif.reset_in);
			next_s.both = lif.set_in & lif.reset_in;
		end
		next_s.q = next_s.st | next_s.both;
		next_s.q_n = ~next_s.st | next_s.both;
		next_s.unst = |next_s.both;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign lif.q = s.q;
	assign lif.q_n = s.q_n;
	assign lif.unstable = s.unst;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_latch_gate_hold: assert property (
		!lif.gate && lif.preset_n && lif.async_clear_n |=> $stable(lif.q))
		else $error("latch output moved with gate low");
	a_latch_pass_set: assert property (
		lif.gate && lif.preset_n && lif.async_clear_n
		|=> lif.q == ($past(lif.set_in) | ($past(lif.q) & ~$past(lif.reset_in)
			& ~$past(lif.set_in & lif.reset_in)) | $past(lif.set_in)))
		else $error("latch did not follow its inputs");
endmodule : fflb_latch
`default_nettype wire

// >>> fflb_latch_if.sv
// Connection between the bank top and one gated latch group.
`timescale 1ns/1ps
`default_nettype none
interface fflb_latch_if #(parameter int N = 4);
	logic gate;
	logic preset_n;
	logic async_clear_n;
	logic [N-1:0] set_in;
	logic [N-1:0] reset_in;
	logic [N-1:0] q;
	logic [N-1:0] q_n;
	logic unstable;
	modport bank (output gate, output preset_n, output async_clear_n,
		output set_in, output reset_in, input q, input q_n, input unstable);
	modport latch (input gate, input preset_n, input async_clear_n,
		input set_in, input reset_in, output q, output q_n,
		output unstable);
endinterface : fflb_latch_if
`default_nettype wire

// >>> fflb_pkg.sv
// Types and helpers shared by the storage bank modules.
package fflb_pkg;
	typedef enum logic [1:0] {
		FFLB_JK_HOLD,
		FFLB_JK_CLEAR,
		FFLB_JK_SET,
		FFLB_JK_TOGGLE
	} fflb_jk_t;

	function automatic fflb_jk_t fflb_jk_decode(input logic j, input logic k);
		fflb_jk_t a;
		unique case ({j, k})
			2'b00: a = FFLB_JK_HOLD;
			2'b01: a = FFLB_JK_CLEAR;
			2'b10: a = FFLB_JK_SET;
			2'b11: a = FFLB_JK_TOGGLE;
		endcase
		return a;
	endfunction : fflb_jk_decode

	function automatic logic fflb_jk_next(input logic q, input logic j,
			input logic k);
		logic n;
		unique case (fflb_jk_decode(j, k))
			FFLB_JK_HOLD: n = q;
			FFLB_JK_CLEAR: n = 1'b0;
			FFLB_JK_SET: n = 1'b1;
			FFLB_JK_TOGGLE: n = ~q;
		endcase
		return n;
	endfunction : fflb_jk_next
endpackage : fflb_pkg

// >>> testbench.sv
// Self-checking bench for the storage bank with a reference model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk;
	logic rstn;
	logic primed;
	logic [31:0] seed;
	logic [4:0] sc [6];
	logic [3:0] sa [6];
	logic [3:0] sb [6];
	logic [4:0] pc [6];
	logic [3:0] pa [6];
	logic [3:0] pb [6];
	logic [3:0] mq [6];
	logic [3:0] mqn [6];
	logic [5:0] mu;
	logic [5:0] prv;
	wire logic [3:0] oq [6];
	wire logic [3:0] oqn [6];
	wire logic [5:0] ou;
	int num_errors = 0;
	int compares = 0;

	fflb_far far (.mclk(mclk), .rstn(rstn), .sc(sc), .sa(sa), .sb(sb),
		.pc(pc), .pa(pa), .pb(pb));

	// Groups: 0 rise D, 1 fall JK, 2 dual D, 3 dual JK, 4 SR, 5 D latch.
	fflb_bank #(.RW(4), .LW(4)) dut (.mclk(mclk), .rstn(rstn),
		.rd_clk(pc[0][4]), .rd_preset_n(pc[0][3]),
		.rd_async_clear_n(pc[0][2]), .rd_d(pa[0]),
		.rd_q(oq[0]), .rd_q_n(oqn[0]), .rd_unstable(ou[0]),
		.fj_clk(pc[1][4]), .fj_preset_n(pc[1][3]),
		.fj_async_clear_n(pc[1][2]), .fj_j(pa[1]), .fj_k(pb[1]),
		.fj_q(oq[1]), .fj_q_n(oqn[1]), .fj_unstable(ou[1]),
		.dd_clk(pc[2][4]), .dd_rise_edge_enable(pc[2][1]),
		.dd_fall_edge_enable(pc[2][0]), .dd_preset_n(pc[2][3]),
		.dd_async_clear_n(pc[2][2]), .dd_d(pa[2]),
		.dd_q(oq[2]), .dd_q_n(oqn[2]), .dd_unstable(ou[2]),
		.dj_clk(pc[3][4]), .dj_rise_edge_enable(pc[3][1]),
		.dj_fall_edge_enable(pc[3][0]), .dj_preset_n(pc[3][3]),
		.dj_async_clear_n(pc[3][2]), .dj_j(pa[3]), .dj_k(pb[3]),
		.dj_q(oq[3]), .dj_q_n(oqn[3]), .dj_unstable(ou[3]),
		.sr_gate(pc[4][4]), .sr_preset_n(pc[4][3]),
		.sr_async_clear_n(pc[4][2]), .sr_set(pa[4]), .sr_reset(pb[4]),
		.sr_q(oq[4]), .sr_q_n(oqn[4]), .sr_unstable(ou[4]),
		.dl_gate(pc[5][4]), .dl_preset_n(pc[5][3]),
		.dl_async_clear_n(pc[5][2]), .dl_d(pa[5]),
		.dl_q(oq[5]), .dl_q_n(oqn[5]), .dl_unstable(ou[5]));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		for (int i = 0; i < 16; i++)
			x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
		return x;
	endfunction : lfsr

	function automatic void step(input int g);
		logic [4:0] c;
		logic [3:0] x;
		logic [3:0] y;
		logic [3:0] n;
		logic rise;
		logic fall;
		logic act;
		c = pc[g];
		x = pa[g];
		y = pb[g];
		rise = primed & c[4] & ~prv[g];
		fall = primed & ~c[4] & prv[g];
		act = (g == 0) ? rise : (g == 1) ? fall : (g > 3) ? c[4] :
			(rise & c[1]) | (fall & c[0]);
		if (g == 1 || g == 3)
			n = (x & ~mq[g]) | (~y & mq[g]);
		else if (g == 4)
			n = x | (~y & mq[g]);
		else
			n = x;
		mq[g] = act ? n : mq[g];
		mqn[g] = ~mq[g] | ((g == 4 && act) ? (x & y) : 4'h0);
		mu[g] = (g == 4) && act && (|(x & y));
		if (!c[3] && !c[2]) begin
			mq[g] = 4'hF;
			mqn[g] = 4'hF;
			mu[g] = 1'b1;
		end else if (!c[2] || !c[3]) begin
			mq[g] = c[2] ? 4'hF : 4'h0;
			mqn[g] = ~mq[g];
			mu[g] = 1'b0;
		end
		prv[g] = c[4];
	endfunction : step

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int g = 0; g < 6; g++) begin
				mq[g] = 4'h0;
				mqn[g] = 4'hF;
			end
			mu = 6'h00;
			primed = 1'b0;
		end else begin
			for (int g = 0; g < 6; g++)
				step(g);
			primed = 1'b1;
		end
	end

	task automatic chkv(input string n, input int g, input logic [3:0] e,
			input logic [3:0] s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s group %0d expected %h seen %h", n, g, e, s);
		end
	endtask : chkv

	task automatic chkb(input int g, input logic e, input logic s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR unstable group %0d expected %b seen %b", g, e, s);
		end
	endtask : chkb

	always @(negedge mclk) begin
		if (rstn && primed) begin
			for (int g = 0; g < 6; g++) begin
				chkv("q", g, mq[g], oq[g]);
				chkv("q_n", g, mqn[g], oqn[g]);
				chkb(g, mu[g], ou[g]);
			end
		end
	end

	// Mode 0 random, 1 preset and clear both low, 2 toggle, 3 idle.
	task automatic drive(input int m);
		for (int g = 0; g < 6; g++) begin
			seed = lfsr(seed);
			case (m)
				0: begin
					sc[g] <= {seed[0], |seed[2:1], |seed[4:3], seed[6:5]};
					sa[g] <= seed[11:8];
					sb[g] <= seed[15:12];
				end
				1: sc[g] <= {seed[0], 2'b00, seed[6:5]};
				2: begin
					sc[g] <= {~sc[g][4], 4'hF};
					sa[g] <= 4'hF;
					sb[g] <= 4'hF;
				end
				default: sc[g] <= 5'h0C;
			endcase
		end
	endtask : drive

	task automatic run(input int n, input int m);
		repeat (n) begin
			@(posedge mclk);
			drive(m);
		end
	endtask : run

	task automatic summarize;
		$display("Comparisons %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		#30000;
		num_errors++;
		$display("ERROR watchdog expired");
		summarize();
	end

	initial begin
		rstn = 1'b0;
		seed = 32'hE734;
		for (int g = 0; g < 6; g++) begin
			sc[g] = 5'h0C;
			sa[g] = 4'h0;
			sb[g] = 4'h0;
		end
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		run(2, 3);
		run(500, 0);
		run(3, 1);
		run(20, 2);
		run(2, 1);
		run(500, 0);
		@(posedge mclk);
		rstn <= 1'b0;
		run(3, 3);
		rstn <= 1'b1;
		run(2, 3);
		run(500, 0);
		run(9, 2);
		run(2, 3);
		summarize();
	end
endmodule : testbench
`default_nettype wire
